// ===== hdl/xfer_pkg.sv
// Constants shared by the single-transfer engine and its helpers
package xfer_pkg;

   // ------------------------------------------------------------
   // Register indices and byte offsets on the Wishbone slave
   // ------------------------------------------------------------
   localparam logic [2:0] IDX_COUNT_VIEW   = 3'h0; // transfer_count index
   localparam logic [2:0] IDX_CONTROL_VIEW = 3'h1; // transfer_control index
   localparam logic [7:0] OFF_COUNT_VIEW   = 8'h00;
   localparam logic [7:0] OFF_CONTROL_VIEW = 8'h04;
   localparam logic [7:0] OFF_ENABLE       = 8'h08;
   localparam logic [7:0] OFF_CB_BASE      = 8'h0C;
   localparam logic [7:0] OFF_STATUS       = 8'h10;
   localparam logic [7:0] OFF_MASK         = 8'h14;
   localparam logic [7:0] OFF_STATE        = 8'h18;

   // ------------------------------------------------------------
   // Control block layout in memory (byte offsets from its base)
   // ------------------------------------------------------------
   localparam logic [15:0] CB_COUNT_OFF = 16'h0000;
   localparam logic [15:0] CB_CON_OFF   = 16'h0001;
   localparam logic [15:0] CB_SRC_OFF   = 16'h0002;
   localparam logic [15:0] CB_DST_OFF   = 16'h0004;

   // ------------------------------------------------------------
   // Fields of the control byte
   // ------------------------------------------------------------
   localparam int         MODE_HI     = 7;
   localparam int         MODE_LO     = 5;
   localparam int         BIT_SIZE    = 4;
   localparam int         BIT_SRC_UPD = 3;
   localparam int         BIT_DST_UPD = 2;
   localparam int         BIT_SRC_INC = 1;
   localparam int         BIT_DST_INC = 0;
   localparam logic [2:0] MODE_SINGLE = 3'h4;

   // ------------------------------------------------------------
   // Status bits, pointer steps and reset values
   // ------------------------------------------------------------
   localparam int         ST_DONE     = 0;
   localparam int         ST_CYCLE    = 1;
   localparam int         ST_ERROR    = 2;
   localparam int         ST_OVERRUN  = 3;
   localparam int         ST_WIDTH    = 4;
   localparam logic [15:0] STEP_WORD  = 16'h0002;
   localparam logic [15:0] STEP_BYTE  = 16'h0001;
   localparam logic [15:0] RST_CB_BASE = 16'h0000;
   localparam logic [3:0]  RST_MASK    = 4'h0;
   localparam logic [3:0]  RST_STATUS  = 4'h0;
   localparam logic        RST_ENABLE  = 1'b0;

   // Engine sequencer states
   typedef enum logic [3:0] {
      S_IDLE, S_RD_HDR, S_RD_SRC, S_RD_DST, S_RD_DATA,
      S_WR_DATA, S_WR_SRC, S_WR_DST, S_WR_CNT, S_FINISH
   } xfer_state_t;

endpackage

// ===== hdl/ptr_update.sv
// Next-value and write-back value of one control block pointer
`timescale 1ns/1ps
module ptr_update #(
   parameter int W = 16
) (
   // Current pointer and its controls
   input  wire logic [W-1:0] ptr_i,
   input  wire logic         inc_i,
   input  wire logic         keep_i,
   input  wire logic         byte_i,
   // Results
   output logic      [W-1:0] next_o,
   output logic      [W-1:0] store_o
);

   // ------------------------------------------------------------
   // Step, advance and keep-or-restore
   // ------------------------------------------------------------
   wire logic [W-1:0] step;
   assign step    = byte_i ? W'(xfer_pkg::STEP_BYTE)
                           : W'(xfer_pkg::STEP_WORD);
   assign next_o  = inc_i ? ptr_i + step : ptr_i;
   assign store_o = keep_i ? next_o : ptr_i;

endmodule // ptr_update

// ===== hdl/single_xfer_engine.sv
// Interrupt-driven single-transfer engine with Wishbone registers
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
module single_xfer_engine #(
   parameter int AW = 16
) (
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // Wishbone slave
   input  wire logic          cyc_i,
   input  wire logic          stb_i,
   input  wire logic          we_i,
   input  wire logic [7:0]    adr_i,
   input  wire logic [3:0]    sel_i,
   input  wire logic [31:0]   dat_i,
   output logic      [31:0]   dat_o,
   output logic               ack_o,
   // Service request and interrupt
   input  wire logic          service_req_i,
   output logic               irq_o,
   // Memory master
   output logic               mem_req_o,
   output logic               mem_we_o,
   output logic               mem_byte_o,
   output logic      [AW-1:0] mem_addr_o,
   output logic      [15:0]   mem_wdata_o,
   input  wire logic [15:0]   mem_rdata_i,
   input  wire logic          mem_ack_i
);

   // ------------------------------------------------------------
   // State and registers
   // ------------------------------------------------------------
   xfer_pkg::xfer_state_t state_r, state_nxt;
   logic [7:0]    count_r;
   logic [7:0]    control_r;
   logic [AW-1:0] src_r;
   logic [AW-1:0] dst_r;
   logic [15:0]   data_r;
   logic [AW-1:0] cb_base_r;
   logic          enable_r;
   logic [3:0]    status_r;
   logic [3:0]    mask_r;
   logic          pending_r;
   logic          req_r;
   logic          we_r;
   logic          byte_r;
   logic [AW-1:0] addr_r;
   logic [15:0]   wdata_r;
   logic [31:0]   rdata_r;
   logic          ack_r;
   // ------------------------------------------------------------
   // Control byte fields
   // ------------------------------------------------------------
   wire logic [2:0] mode_code;
   wire logic       size_select;
   wire logic       source_update;
   wire logic       destination_update;
   wire logic       source_increment;
   wire logic       destination_increment;
   assign mode_code = control_r[xfer_pkg::MODE_HI:xfer_pkg::MODE_LO];
   assign size_select           = control_r[xfer_pkg::BIT_SIZE];
   assign source_update         = control_r[xfer_pkg::BIT_SRC_UPD];
   assign destination_update    = control_r[xfer_pkg::BIT_DST_UPD];
   assign source_increment      = control_r[xfer_pkg::BIT_SRC_INC];
   assign destination_increment = control_r[xfer_pkg::BIT_DST_INC];
   // ------------------------------------------------------------
   // Pointer updates
   // ------------------------------------------------------------
   wire logic [AW-1:0] src_store;
   wire logic [AW-1:0] dst_store;
   ptr_update #(.W(AW)) u_src_ptr (
      .ptr_i   (src_r),
      .inc_i   (source_increment),
      .keep_i  (source_update),
      .byte_i  (size_select),
      .next_o  (),
      .store_o (src_store)
   );
   ptr_update #(.W(AW)) u_dst_ptr (
      .ptr_i   (dst_r),
      .inc_i   (destination_increment),
      .keep_i  (destination_update),
      .byte_i  (size_select),
      .next_o  (),
      .store_o (dst_store)
   );
   // ------------------------------------------------------------
   // Sequencer decode
   // ------------------------------------------------------------
   wire logic         access_done;
   wire logic         start;
   wire logic         hdr_ok;
   wire logic [7:0]   count_dec;
   wire logic [7:0]   hdr_count;
   wire logic [7:0]   hdr_control;
   assign access_done = req_r & mem_ack_i;
   assign start       = (state_r == xfer_pkg::S_IDLE) & enable_r &
                        (pending_r | service_req_i);
   assign hdr_count   = mem_rdata_i[7:0];
   assign hdr_control = mem_rdata_i[15:8];
   assign hdr_ok      = (hdr_control[xfer_pkg::MODE_HI:xfer_pkg::MODE_LO]
                         == xfer_pkg::MODE_SINGLE) &
                        (hdr_count != 8'h00);
   assign count_dec   = count_r - 8'h01;
   // Next state
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         xfer_pkg::S_IDLE:    if (start) state_nxt = xfer_pkg::S_RD_HDR;
         xfer_pkg::S_RD_HDR:
            if (access_done)
               state_nxt = hdr_ok ? xfer_pkg::S_RD_SRC
                                  : xfer_pkg::S_FINISH;
         xfer_pkg::S_RD_SRC:  if (access_done) state_nxt = xfer_pkg::S_RD_DST;
         xfer_pkg::S_RD_DST:  if (access_done) state_nxt = xfer_pkg::S_RD_DATA;
         xfer_pkg::S_RD_DATA: if (access_done) state_nxt = xfer_pkg::S_WR_DATA;
         xfer_pkg::S_WR_DATA: if (access_done) state_nxt = xfer_pkg::S_WR_SRC;
         xfer_pkg::S_WR_SRC:  if (access_done) state_nxt = xfer_pkg::S_WR_DST;
         xfer_pkg::S_WR_DST:  if (access_done) state_nxt = xfer_pkg::S_WR_CNT;
         xfer_pkg::S_WR_CNT:  if (access_done) state_nxt = xfer_pkg::S_FINISH;
         xfer_pkg::S_FINISH:  state_nxt = xfer_pkg::S_IDLE;
         default:             state_nxt = xfer_pkg::S_IDLE;
      endcase
   end
   // Memory access set up for the state being entered
   logic [AW-1:0] addr_nxt;
   logic [15:0]   wdata_nxt;
   logic          we_nxt;
   logic          byte_nxt;
   always_comb
   begin
      addr_nxt  = addr_r;
      wdata_nxt = 16'h0000;
      we_nxt    = 1'b0;
      byte_nxt  = 1'b0;
      case (state_nxt)
         xfer_pkg::S_RD_HDR:  addr_nxt = cb_base_r + AW'(xfer_pkg::CB_COUNT_OFF);
         xfer_pkg::S_RD_SRC:  addr_nxt = cb_base_r + AW'(xfer_pkg::CB_SRC_OFF);
         xfer_pkg::S_RD_DST:  addr_nxt = cb_base_r + AW'(xfer_pkg::CB_DST_OFF);
         xfer_pkg::S_RD_DATA:
         begin
            addr_nxt = src_r;
            byte_nxt = size_select;
         end
         xfer_pkg::S_WR_DATA:
         begin
            addr_nxt  = dst_r;
            byte_nxt  = size_select;
            we_nxt    = 1'b1;
            wdata_nxt = size_select ? {8'h00, data_r[7:0]} : data_r;
         end
         xfer_pkg::S_WR_SRC:
         begin
            addr_nxt  = cb_base_r + AW'(xfer_pkg::CB_SRC_OFF);
            we_nxt    = 1'b1;
            wdata_nxt = 16'(src_store);
         end
         xfer_pkg::S_WR_DST:
         begin
            addr_nxt  = cb_base_r + AW'(xfer_pkg::CB_DST_OFF);
            we_nxt    = 1'b1;
            wdata_nxt = 16'(dst_store);
         end
         xfer_pkg::S_WR_CNT:
         begin
            addr_nxt  = cb_base_r + AW'(xfer_pkg::CB_COUNT_OFF);
            we_nxt    = 1'b1;
            byte_nxt  = 1'b1;
            wdata_nxt = {8'h00, count_dec};
         end
         default:             addr_nxt = addr_r;
      endcase
   end
   // Sequencer and memory request registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r <= xfer_pkg::S_IDLE;
         req_r   <= 1'b0;
         addr_r  <= '0;
         wdata_r <= 16'h0000;
         we_r    <= 1'b0;
         byte_r  <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         addr_r  <= addr_nxt;
         wdata_r <= wdata_nxt;
         we_r    <= we_nxt;
         byte_r  <= byte_nxt;
         // One idle cycle between accesses, held until ack
         if (access_done)
            req_r <= 1'b0;
         else if (!req_r && state_r != xfer_pkg::S_IDLE &&
                  state_r != xfer_pkg::S_FINISH && state_nxt == state_r)
            req_r <= 1'b1;
      end
   end
   // Working copy of the control block
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count_r   <= 8'h00;
         control_r <= 8'h00;
         src_r     <= '0;
         dst_r     <= '0;
         data_r    <= 16'h0000;
      end
      else if (access_done)
      begin
         case (state_r)
            xfer_pkg::S_RD_HDR:
            begin
               count_r   <= hdr_count;
               control_r <= hdr_control;
            end
            xfer_pkg::S_RD_SRC:  src_r  <= AW'(mem_rdata_i);
            xfer_pkg::S_RD_DST:  dst_r  <= AW'(mem_rdata_i);
            xfer_pkg::S_RD_DATA: data_r <= mem_rdata_i;
            xfer_pkg::S_WR_CNT:  count_r <= count_dec;
            default:             data_r <= data_r;
         endcase
      end
   end
   // ------------------------------------------------------------
   // Events
   // ------------------------------------------------------------
   wire logic [3:0] events;
   wire logic       ev_cycle;
   wire logic       ev_error;
   assign ev_cycle = (state_r == xfer_pkg::S_WR_CNT) & access_done;
   assign ev_error = (state_r == xfer_pkg::S_RD_HDR) & access_done & ~hdr_ok;
   assign events[xfer_pkg::ST_DONE]    = ev_cycle & (count_dec == 8'h00);
   assign events[xfer_pkg::ST_CYCLE]   = ev_cycle;
   assign events[xfer_pkg::ST_ERROR]   = ev_error;
   assign events[xfer_pkg::ST_OVERRUN] = service_req_i & pending_r &
                                         (state_r != xfer_pkg::S_IDLE);
   // ------------------------------------------------------------
   // Wishbone decode
   // ------------------------------------------------------------
   wire logic       bus_req;
   wire logic       bus_wr;
   wire logic [3:0] w1c;
   logic [31:0]     rdata_nxt;
   assign bus_req = cyc_i & stb_i & ~ack_r;
   assign bus_wr  = bus_req & we_i;
   assign w1c     = (bus_wr && adr_i == xfer_pkg::OFF_STATUS && sel_i[0])
                    ? dat_i[3:0] : 4'h0;
   // Read multiplexer
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      case (adr_i)
         xfer_pkg::OFF_COUNT_VIEW:   rdata_nxt[7:0]  = count_r;
         xfer_pkg::OFF_CONTROL_VIEW: rdata_nxt[7:0]  = control_r;
         xfer_pkg::OFF_ENABLE:       rdata_nxt[0]    = enable_r;
         xfer_pkg::OFF_CB_BASE:      rdata_nxt[AW-1:0] = cb_base_r;
         xfer_pkg::OFF_STATUS:       rdata_nxt[3:0]  = status_r;
         xfer_pkg::OFF_MASK:         rdata_nxt[3:0]  = mask_r;
         xfer_pkg::OFF_STATE:
            rdata_nxt[1:0] = {pending_r, state_r != xfer_pkg::S_IDLE};
         default:                    rdata_nxt = 32'h0000_0000;
      endcase
   end
   // Bus answer and software registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_r     <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         enable_r  <= xfer_pkg::RST_ENABLE;
         cb_base_r <= AW'(xfer_pkg::RST_CB_BASE);
         mask_r    <= xfer_pkg::RST_MASK;
      end
      else
      begin
         ack_r   <= bus_req;
         rdata_r <= bus_req ? rdata_nxt : rdata_r;
         if (bus_wr && adr_i == xfer_pkg::OFF_ENABLE && sel_i[0])
            enable_r <= dat_i[0];
         if (bus_wr && adr_i == xfer_pkg::OFF_CB_BASE)
         begin
            if (sel_i[0]) cb_base_r[7:0]  <= dat_i[7:0];
            if (sel_i[1]) cb_base_r[15:8] <= dat_i[15:8];
         end
         if (bus_wr && adr_i == xfer_pkg::OFF_MASK && sel_i[0])
            mask_r <= dat_i[3:0];
      end
   end
   // Sticky status and pending request; a new event wins over a clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         status_r  <= xfer_pkg::RST_STATUS;
         pending_r <= 1'b0;
      end
      else
      begin
         status_r <= (status_r & ~w1c) | events;
         if (service_req_i && !(start && !pending_r))
            pending_r <= 1'b1;
         else if (start)
            pending_r <= 1'b0;
      end
   end
   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign dat_o       = rdata_r;
   assign ack_o       = ack_r;
   assign irq_o       = |(status_r & mask_r);
   assign mem_req_o   = req_r;
   assign mem_we_o    = we_r;
   assign mem_byte_o  = byte_r;
   assign mem_addr_o  = addr_r;
   assign mem_wdata_o = wdata_r;
endmodule // single_xfer_engine

// ===== test/single_xfer_engine_properties.sv
// Port-level concurrent checks for the single-transfer engine
`timescale 1ns/1ps
module xfer_props #(
   parameter int AW = 16
) (
   // Clock and reset
   input wire logic          clk_i,
   input wire logic          rst_i,
   // Wishbone slave
   input wire logic          cyc_i,
   input wire logic          stb_i,
   input wire logic          we_i,
   input wire logic [7:0]    adr_i,
   input wire logic [3:0]    sel_i,
   input wire logic [31:0]   dat_i,
   input wire logic [31:0]   dat_o,
   input wire logic          ack_o,
   // Service request and interrupt
   input wire logic          service_req_i,
   input wire logic          irq_o,
   // Memory master
   input wire logic          mem_req_o,
   input wire logic          mem_we_o,
   input wire logic          mem_byte_o,
   input wire logic [AW-1:0] mem_addr_o,
   input wire logic [15:0]   mem_wdata_o,
   input wire logic [15:0]   mem_rdata_i,
   input wire logic          mem_ack_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ------------------------------------------------------------
   // Bus steps
   // ------------------------------------------------------------
   sequence s_take; cyc_i && stb_i && !ack_o; endsequence
   sequence s_acc; mem_req_o && mem_ack_i; endsequence
   sequence s_word_wr; mem_we_o && !mem_byte_o; endsequence

   property p_ack_resp; s_take |=> ack_o; endproperty
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
   property p_dat_hold; !(cyc_i && stb_i) |=> $stable(dat_o); endproperty
   property p_req_hold;
      mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
         && $stable(mem_wdata_o) && $stable({mem_we_o, mem_byte_o});
   endproperty
   property p_req_gap; s_acc |=> !mem_req_o; endproperty
   property p_next_acc;
      s_acc ##0 s_word_wr |=> !mem_req_o ##1 mem_req_o;
   endproperty
   property p_irq_cause;
      $rose(irq_o) |-> $past(mem_ack_i) || $past(cyc_i && stb_i && we_i)
         || $past(service_req_i);
   endproperty

   a_ack_resp: assert property (p_ack_resp)
      else $error("bus access not answered");
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   a_dat_hold: assert property (p_dat_hold)
      else $error("read data moved while idle");
   a_req_hold: assert property (p_req_hold)
      else $error("memory request changed before ack");
   a_req_gap: assert property (p_req_gap)
      else $error("memory request held past ack");
   a_next_acc: assert property (p_next_acc)
      else $error("write-back sequence broken");
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt rose without cause");
endmodule // xfer_props

// ===== test/xfer_mem_model.sv
// Byte memory answering the engine's request and ack port
`timescale 1ns/1ps
module xfer_mem_model (
   // Clock
   input wire logic        clk_i,
   // Request side
   input wire logic        req_i,
   input wire logic        we_i,
   input wire logic        byte_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wdata_i,
   // Answer side
   output logic     [15:0] rdata_o,
   output logic            ack_o
);
   logic [7:0] mem [0:65535];
   logic [1:0] wait_r;

   initial
   begin
      rdata_o = 16'h0000;
      ack_o = 1'b0;
      wait_r = 2'h0;
   end

   // Random wait, then one-cycle ack; data toggles when not valid
   always @(posedge clk_i)
   begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o && wait_r != 2'h0)
         wait_r <= wait_r - 2'h1;
      else if (req_i && !ack_o)
      begin
         ack_o <= 1'b1;
         wait_r <= 2'($urandom % 3);
         rdata_o <= {mem[addr_i + 1], mem[addr_i]};
         if (we_i)
            mem[addr_i] <= wdata_i[7:0];
         if (we_i && !byte_i)
            mem[addr_i + 1] <= wdata_i[15:8];
      end
   end
endmodule // xfer_mem_model

// ===== test/test_single_xfer_engine.sv
// Self-checking bench for the single-transfer engine
`timescale 1ns/1ps
module test_single_xfer_engine;
   localparam logic [15:0] CB = 16'h0100;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic        service_req_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic        ack_o, irq_o, mem_req_o, mem_we_o, mem_byte_o, mem_ack_i;
   logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
   int          n_fail = 0, n_compared = 0, cycles = 0;

   single_xfer_engine #(.AW(16)) DUT (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .service_req_i(service_req_i), .irq_o(irq_o),
      .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_byte_o(mem_byte_o),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
      .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i));
   xfer_mem_model MEM (.clk_i(clk_i), .req_i(mem_req_o), .we_i(mem_we_o),
      .byte_i(mem_byte_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
      .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));

   // Clock and hang guard
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         n_fail++;
         end_sim();
      end
   end

   task end_sim;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask

   // One classic Wishbone cycle; read data lands in q
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   function automatic logic [15:0] nptr(logic [15:0] p, logic inc,
                                        logic keep, logic byt);
      return (keep && inc) ? p + (byt ? 16'h0001 : 16'h0002) : p;
   endfunction

   // One service request against a freshly loaded control block
   task automatic run(input int i);
      logic [7:0]  ctl, cnt;
      logic [15:0] src, dst, sd, pd;
      logic        ok, byt;
      ctl = {3'h4, 5'($urandom)};
      if (i < 8)
         ctl[7:5] = i[2:0];
      cnt = (i % 3 == 0) ? 8'h01 : 8'($urandom_range(2, 254));
      if (i == 10)
         cnt = 8'hFF;
      if (i == 11)
         cnt = 8'h00;
      src = 16'h2000 | (16'($urandom) & 16'h0FFE);
      dst = 16'h4000 | (16'($urandom) & 16'h0FFE);
      sd = 16'($urandom);
      pd = 16'($urandom);
      {MEM.mem[CB + 1], MEM.mem[CB]} = {ctl, cnt};
      {MEM.mem[CB + 3], MEM.mem[CB + 2]} = src;
      {MEM.mem[CB + 5], MEM.mem[CB + 4]} = dst;
      {MEM.mem[src + 1], MEM.mem[src]} = sd;
      {MEM.mem[dst + 1], MEM.mem[dst]} = pd;
      @(posedge clk_i);
      service_req_i <= 1'b1;
      @(posedge clk_i);
      service_req_i <= 1'b0;
      for (int k = 0; k < 100; k++)
      begin
         wb(1'b0, 8'h18, 32'h0);
         if (q[0] === 1'b0)
            break;
      end
      ok = (ctl[7:5] == 3'h4) && cnt != 8'h00;
      byt = ctl[4];
      chk("dst low", ok ? sd[7:0] : pd[7:0], MEM.mem[dst]);
      chk("dst high", (ok && !byt) ? sd[15:8] : pd[15:8],
          MEM.mem[dst + 1]);
      chk("src ptr", ok ? nptr(src, ctl[1], ctl[3], byt) : src,
          {MEM.mem[CB + 3], MEM.mem[CB + 2]});
      chk("dst ptr", ok ? nptr(dst, ctl[0], ctl[2], byt) : dst,
          {MEM.mem[CB + 5], MEM.mem[CB + 4]});
      chk("count", ok ? cnt - 8'h01 : cnt, MEM.mem[CB]);
      wb(1'b0, 8'h10, 32'h0);
      chk("status", {1'b0, !ok, ok, ok && cnt == 8'h01}, q[3:0]);
      chk("irq", ok && cnt == 8'h01, irq_o);
      wb(1'b1, 8'h10, 32'h0000000F);
      chk("irq cleared", 32'h0, irq_o);
      if (ok)
      begin
         wb(1'b0, 8'h00, 32'h0);
         chk("count view", cnt - 8'h01, q[7:0]);
         wb(1'b0, 8'h04, 32'h0);
         chk("control view", ctl, q[7:0]);
      end
   endtask

   // Reset values, unmapped place, setup, then the service runs
   initial
   begin
      void'($urandom(32'hB926));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a <= 8'h1C; a += 4)
      begin
         wb(1'b0, 8'(a), 32'h0);
         chk("reset reg", 32'h0, q);
      end
      wb(1'b1, 8'hFC, 32'hFFFFFFFF);
      wb(1'b0, 8'hFC, 32'h0);
      chk("unmapped", 32'h0, q);
      wb(1'b1, 8'h0C, {16'h0000, CB});
      wb(1'b0, 8'h0C, 32'h0);
      chk("cb base", {16'h0000, CB}, q);
      wb(1'b1, 8'h14, 32'h00000001);
      wb(1'b1, 8'h08, 32'h00000001);
      for (int i = 0; i < 16; i++)
         run(i);
      // Request while disabled waits pending; refused header, no write
      {MEM.mem[CB + 1], MEM.mem[CB]} = 16'h0001;
      wb(1'b1, 8'h08, 32'h0);
      @(posedge clk_i);
      service_req_i <= 1'b1;
      @(posedge clk_i);
      service_req_i <= 1'b0;
      wb(1'b0, 8'h18, 32'h0);
      chk("pending", 32'h2, q);
      wb(1'b1, 8'h08, 32'h1);
      repeat (20) @(posedge clk_i);
      // Three request cycles: start, pending, then overrun
      service_req_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      service_req_i <= 1'b0;
      repeat (60) @(posedge clk_i);
      wb(1'b0, 8'h10, 32'h0);
      chk("overrun", 32'hC, q);
      wb(1'b0, 8'h18, 32'h0);
      chk("idle", 32'h0, q);
      chk("header kept", 32'h0001, {MEM.mem[CB + 1], MEM.mem[CB]});
      end_sim();
   end
endmodule // test_single_xfer_engine

bind single_xfer_engine xfer_props #(.AW(AW)) u_props (.clk_i(clk_i),
   .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
   .ack_o(ack_o), .service_req_i(service_req_i), .irq_o(irq_o),
   .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_byte_o(mem_byte_o),
   .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
   .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i));
